// ===== src/serial_port_pkg.sv
// Purpose: shared constants for the serial data registers and alternative flags
// Assumes: byte-wide register port, one clock
// Notes: offsets are byte offsets inside the block
package serial_port_pkg;
    localparam logic [3:0] OFF_DATA_HIGH = 4'h6;
    localparam logic [3:0] OFF_DATA_LOW = 4'h7;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_ALT_STATUS_ONE = 4'h1;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h2;
    // data_high fields
    localparam int RX_NINTH_POS = 7;
    localparam int TX_NINTH_POS = 6;
    localparam logic [2:0] TEST_BITS_MASK = 3'h7;
    // ctrl fields
    localparam int CTRL_NINE_BIT_POS = 0;
    localparam int CTRL_POL_POS = 1;
    localparam int CTRL_BERR_EN_POS = 2;
    localparam int CTRL_BRK_EN_POS = 3;
    // alt status / mask fields
    localparam int FLAG_EDGE_POS = 0;
    localparam int FLAG_BERR_POS = 1;
    localparam int FLAG_BRK_POS = 2;
    // reset values
    localparam logic [7:0] DATA_LOW_RESET = 8'h00;
    localparam logic [7:0] DATA_HIGH_RESET = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [2:0] RX_SYNC_RESET = 3'h7;
    localparam logic RX_LEVEL_RESET = 1'b1;
endpackage

// ===== src/serial_data_regs.sv
// Purpose: data holding registers and alternative status flags of the serial port
// Assumes: frame shifter outside delivers received characters and tx bit samples
// Notes: rx pin passes three flops; a change counts when stages two and three agree
//
// Overview of operation
// - reads of the data registers return the receive holding register anytime.
// - writes load the transmit holding register anytime; writes to rx ninth bit ignored.
// - in nine-bit format the received ninth bit reads in data_high bit 7.
// - in nine-bit format data_high bit 6 is sent as ninth bit.
// - the transmit ninth bit keeps its value until software rewrites it.
// - data_low bits 7:0 carry receive on read, transmit on write.
// - rx edge flag sets on falling edge, or rising when polarity is one.
// - writing one to the rx edge flag clears it.
// - single-wire bit error flag sets when readback differs from sent bit.
// - bit error flag clears on write one, or while detection disabled.
// - break flag sets when a break is received while break detection is enabled.
// - break flag clears on write one, or while detection disabled.
// - the interrupt request output can wake the cpu from wait.
// - an active rx edge in stop produces a wakeup output.
// - data_high bits 2:0 are test bits, writable only in special mode.
`timescale 1ns/1ps
module serial_data_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic rx_pin,
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char,
    input wire logic break_seen,
    input wire logic single_wire,
    input wire logic tx_bit_sample,
    input wire logic tx_bit_value,
    input wire logic special_mode,
    input wire logic stop_mode,
    output logic [7:0] tx_data,
    output logic tx_ninth_bit,
    output logic tx_nine_bit_fmt,
    output logic tx_load,
    output logic [2:0] test_bits,
    output logic irq,
    output logic stop_wakeup
);
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] rx_low;
        logic rx_ninth_bit;
        logic [7:0] tx_low;
        logic tx_ninth_bit;
        logic [2:0] test_bits;
        logic [3:0] ctrl;
        logic [2:0] flags;
        logic [2:0] mask;
        logic tx_load;
        logic [2:0] rx_sync;
        logic rx_level;
        logic wake;
    } state_s;

    state_s st_reg;
    state_s st_next;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    logic rx_agree;
    logic edge_fall;
    logic edge_rise;
    logic edge_active;
    logic berr_event;
    logic brk_event;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    // stage one feeds only stage two; decisions use stages two and three
    assign rx_agree = (st_reg.rx_sync[1] == st_reg.rx_sync[2]);
    assign edge_fall = rx_agree && st_reg.rx_level && !st_reg.rx_sync[2];
    assign edge_rise = rx_agree && !st_reg.rx_level && st_reg.rx_sync[2];

    always_comb begin
        st_next = st_reg;
        st_next.tx_load = 1'b0;
        flag_set = 3'h0;
        flag_clr = 3'h0;
        edge_active = 1'b0;
        berr_event = 1'b0;
        brk_event = 1'b0;

        st_next.rx_sync = {st_reg.rx_sync[1:0], rx_pin};
        if (rx_agree) begin
            st_next.rx_level = st_reg.rx_sync[2];
        end

        edge_active = st_reg.ctrl[serial_port_pkg::CTRL_POL_POS] ? edge_rise : edge_fall;
        berr_event = single_wire && tx_bit_sample && (tx_bit_value != st_reg.rx_level)
                     && st_reg.ctrl[serial_port_pkg::CTRL_BERR_EN_POS];
        brk_event = break_seen && st_reg.ctrl[serial_port_pkg::CTRL_BRK_EN_POS];
        flag_set[serial_port_pkg::FLAG_EDGE_POS] = edge_active;
        flag_set[serial_port_pkg::FLAG_BERR_POS] = berr_event;
        flag_set[serial_port_pkg::FLAG_BRK_POS] = brk_event;

        if (rx_char_valid) begin
            st_next.rx_low = rx_char[7:0];
            st_next.rx_ninth_bit = st_reg.ctrl[serial_port_pkg::CTRL_NINE_BIT_POS] ? rx_char[8] : 1'b0;
        end

        if (wr_stb) begin
            if (hit(addr, serial_port_pkg::OFF_DATA_LOW)) begin
                st_next.tx_low = wdata;
                st_next.tx_load = 1'b1;
            end
            if (hit(addr, serial_port_pkg::OFF_DATA_HIGH)) begin
                // rx ninth bit position is read-only
                st_next.tx_ninth_bit = wdata[serial_port_pkg::TX_NINTH_POS];
                if (special_mode) begin
                    st_next.test_bits = wdata[2:0] & serial_port_pkg::TEST_BITS_MASK;
                end
            end
            if (hit(addr, serial_port_pkg::OFF_CTRL)) begin
                st_next.ctrl = wdata[3:0];
            end
            if (hit(addr, serial_port_pkg::OFF_ALT_STATUS_ONE)) begin
                flag_clr = wdata[2:0];
            end
            if (hit(addr, serial_port_pkg::OFF_IRQ_MASK)) begin
                st_next.mask = wdata[2:0];
            end
        end
        // a new event beats a software clear in the same cycle
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;
        // a disable wins even over an event, so no flag outlives its detector
        if (!st_next.ctrl[serial_port_pkg::CTRL_BERR_EN_POS]) begin
            st_next.flags[serial_port_pkg::FLAG_BERR_POS] = 1'b0;
        end
        if (!st_next.ctrl[serial_port_pkg::CTRL_BRK_EN_POS]) begin
            st_next.flags[serial_port_pkg::FLAG_BRK_POS] = 1'b0;
        end

        st_next.wake = stop_mode && edge_active;

        st_next.rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                serial_port_pkg::OFF_DATA_LOW: st_next.rdata = st_reg.rx_low;
                serial_port_pkg::OFF_DATA_HIGH: st_next.rdata = {st_reg.rx_ninth_bit, st_reg.tx_ninth_bit,
                                                                 2'b00, 1'b0, st_reg.test_bits};
                serial_port_pkg::OFF_CTRL: st_next.rdata = {4'h0, st_reg.ctrl};
                serial_port_pkg::OFF_ALT_STATUS_ONE: st_next.rdata = {5'h00, st_reg.flags};
                serial_port_pkg::OFF_IRQ_MASK: st_next.rdata = {5'h00, st_reg.mask};
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            // line idles high, so no false edge follows reset
            st_reg.rx_sync <= serial_port_pkg::RX_SYNC_RESET;
            st_reg.rx_level <= serial_port_pkg::RX_LEVEL_RESET;
            st_reg.rx_low <= serial_port_pkg::DATA_LOW_RESET;
            st_reg.tx_low <= serial_port_pkg::DATA_LOW_RESET;
            st_reg.ctrl <= serial_port_pkg::CTRL_RESET;
            st_reg.flags <= serial_port_pkg::FLAGS_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign tx_data = st_reg.tx_low;
    // ninth bit is held, so later frames repeat it until rewritten
    assign tx_ninth_bit = st_reg.tx_ninth_bit;
    assign tx_nine_bit_fmt = st_reg.ctrl[serial_port_pkg::CTRL_NINE_BIT_POS];
    assign tx_load = st_reg.tx_load;
    assign test_bits = st_reg.test_bits;
    // level irq also serves as the wait-mode wakeup
    assign irq = |(st_reg.flags & st_reg.mask);
    assign stop_wakeup = st_reg.wake;

    a_flag_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && edge_active |=> st_reg.flags[serial_port_pkg::FLAG_EDGE_POS])
        else $error("edge event lost");
    a_edge_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_stb && addr == serial_port_pkg::OFF_ALT_STATUS_ONE && wdata[0] && !edge_active
        |=> !st_reg.flags[serial_port_pkg::FLAG_EDGE_POS])
        else $error("edge flag not cleared");
    a_berr_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_reg.ctrl[serial_port_pkg::CTRL_BERR_EN_POS] |-> !st_reg.flags[serial_port_pkg::FLAG_BERR_POS])
        else $error("bit error flag while disabled");
    a_brk_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_reg.ctrl[serial_port_pkg::CTRL_BRK_EN_POS] |-> !st_reg.flags[serial_port_pkg::FLAG_BRK_POS])
        else $error("break flag while disabled");
    a_brk_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && brk_event && st_next.ctrl[serial_port_pkg::CTRL_BRK_EN_POS]
        |=> st_reg.flags[serial_port_pkg::FLAG_BRK_POS])
        else $error("break flag not set");
    a_irq_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_stb && addr == serial_port_pkg::OFF_IRQ_MASK && wdata[2:0] == 3'h0 |=> !irq)
        else $error("irq not gated by mask");
    a_read_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rd_stb && addr == serial_port_pkg::OFF_DATA_LOW && !rx_char_valid
        |=> rdata == $past(st_reg.rx_low))
        else $error("data_low read wrong");
    a_ninth_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(wr_stb && addr == serial_port_pkg::OFF_DATA_HIGH) |=> $stable(tx_ninth_bit))
        else $error("tx ninth bit changed");
    a_stop_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && stop_mode && edge_active |=> stop_wakeup)
        else $error("no stop wakeup");

    // building blocks for the multi-step checks below
    sequence s_data_low_write;
        clk_en && wr_stb && addr == serial_port_pkg::OFF_DATA_LOW;
    endsequence

    sequence s_data_high_write;
        clk_en && wr_stb && addr == serial_port_pkg::OFF_DATA_HIGH;
    endsequence

    // both late stages hold the level opposite to the last accepted one
    sequence s_rx_fall_seen;
        clk_en && st_reg.rx_level && !st_reg.rx_sync[1] && !st_reg.rx_sync[2];
    endsequence

    sequence s_rx_rise_seen;
        clk_en && !st_reg.rx_level && st_reg.rx_sync[1] && st_reg.rx_sync[2];
    endsequence

    sequence s_berr_mismatch;
        clk_en && single_wire && tx_bit_sample && (tx_bit_value != st_reg.rx_level);
    endsequence

    // transmit holding side
    a_tx_load_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_data_low_write
        |=> tx_load)
        else $error("no load pulse after data_low write");

    a_tx_load_drops: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !(wr_stb && addr == serial_port_pkg::OFF_DATA_LOW)
        |=> !tx_load)
        else $error("load pulse longer than one cycle");

    a_tx_data_loaded: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_data_low_write
        |=> tx_data == $past(wdata))
        else $error("transmit byte not loaded");

    a_tx_low_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !(wr_stb && addr == serial_port_pkg::OFF_DATA_LOW)
        |=> $stable(tx_data))
        else $error("transmit byte changed without a write");

    a_ninth_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_data_high_write ##0 wdata[serial_port_pkg::TX_NINTH_POS]
        |=> tx_ninth_bit)
        else $error("tx ninth bit not set");

    a_ninth_cleared: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_data_high_write ##0 !wdata[serial_port_pkg::TX_NINTH_POS]
        |=> !tx_ninth_bit)
        else $error("tx ninth bit not cleared");

    // test bits may alter behaviour, so they only move in special mode
    a_test_bits_written: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_data_high_write ##0 special_mode
        |=> test_bits == $past(wdata[2:0]))
        else $error("test bits not written in special mode");

    a_test_bits_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(clk_en && wr_stb && addr == serial_port_pkg::OFF_DATA_HIGH && special_mode)
        |=> $stable(test_bits))
        else $error("test bits changed outside special mode");

    // receive holding side and read port
    a_rx_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rx_char_valid
        |=> st_reg.rx_low == $past(rx_char[7:0]))
        else $error("received byte not held");

    a_rx_low_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !rx_char_valid
        |=> $stable(st_reg.rx_low))
        else $error("received byte changed without a character");

    a_rx_ninth_eight: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rx_char_valid && !st_reg.ctrl[serial_port_pkg::CTRL_NINE_BIT_POS]
        |=> !st_reg.rx_ninth_bit)
        else $error("rx ninth bit set in eight-bit format");

    a_rx_ninth_nine: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rx_char_valid && st_reg.ctrl[serial_port_pkg::CTRL_NINE_BIT_POS]
        |=> st_reg.rx_ninth_bit == $past(rx_char[8]))
        else $error("rx ninth bit not captured");

    a_read_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rd_stb && addr == serial_port_pkg::OFF_DATA_HIGH
        |=> rdata[serial_port_pkg::RX_NINTH_POS] == $past(st_reg.rx_ninth_bit))
        else $error("data_high read lost rx ninth bit");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !rd_stb
        |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    a_status_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && rd_stb && addr == serial_port_pkg::OFF_ALT_STATUS_ONE
        |=> rdata == {5'h00, $past(st_reg.flags)})
        else $error("status read wrong");

    // receive edge, bit error and break flags
    a_fall_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_rx_fall_seen ##0 !st_reg.ctrl[serial_port_pkg::CTRL_POL_POS]
        |=> st_reg.flags[serial_port_pkg::FLAG_EDGE_POS])
        else $error("falling edge not flagged");

    a_rise_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_rx_rise_seen ##0 st_reg.ctrl[serial_port_pkg::CTRL_POL_POS]
        |=> st_reg.flags[serial_port_pkg::FLAG_EDGE_POS])
        else $error("rising edge not flagged");

    a_sync_level: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && (st_reg.rx_sync[1] != st_reg.rx_sync[2])
        |=> $stable(st_reg.rx_level))
        else $error("line level taken before stages agree");

    a_berr_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_berr_mismatch ##0 (st_reg.ctrl[serial_port_pkg::CTRL_BERR_EN_POS]
        && st_next.ctrl[serial_port_pkg::CTRL_BERR_EN_POS])
        |=> st_reg.flags[serial_port_pkg::FLAG_BERR_POS])
        else $error("bit error not flagged");

    a_berr_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_stb && addr == serial_port_pkg::OFF_ALT_STATUS_ONE
        && wdata[serial_port_pkg::FLAG_BERR_POS] && !berr_event
        |=> !st_reg.flags[serial_port_pkg::FLAG_BERR_POS])
        else $error("bit error flag not cleared");

    a_brk_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_stb && addr == serial_port_pkg::OFF_ALT_STATUS_ONE
        && wdata[serial_port_pkg::FLAG_BRK_POS] && !brk_event
        |=> !st_reg.flags[serial_port_pkg::FLAG_BRK_POS])
        else $error("break flag not cleared");

    // wakeup paths, format bit write and clock-enable freeze
    a_wake_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !(stop_mode && edge_active)
        |=> !stop_wakeup)
        else $error("stop wakeup without an edge");

    a_wake_only_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !stop_mode
        |=> !stop_wakeup)
        else $error("stop wakeup outside stop");

    a_irq_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && edge_active && st_reg.mask[serial_port_pkg::FLAG_EDGE_POS]
        && !(wr_stb && addr == serial_port_pkg::OFF_IRQ_MASK)
        |=> irq)
        else $error("enabled edge raised no interrupt");

    a_ctrl_format: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_stb && addr == serial_port_pkg::OFF_CTRL
        |=> tx_nine_bit_fmt == $past(wdata[serial_port_pkg::CTRL_NINE_BIT_POS]))
        else $error("format bit not written");

    a_freeze_state: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en
        |=> $stable(st_reg))
        else $error("state moved while clock enable low");
endmodule

// ===== verification/serial_peer.sv
// Purpose: remote serial node feeding the receive side
// Assumes: framing is done upstream; characters and breaks arrive as pulses
// Notes: released bus lines show the inverted value, never a stale one
`timescale 1ns/1ps
module serial_peer (
    input wire logic core_clk,
    output logic rx_pin,
    output logic rx_char_valid,
    output logic [8:0] rx_char,
    output logic break_seen
);
    initial begin
        rx_pin = 1'b1;
        rx_char_valid = 1'b0;
        rx_char = 9'h000;
        break_seen = 1'b0;
    end
    task automatic send_char(input logic [8:0] c);
        @(posedge core_clk) rx_char_valid <= 1'b1;
        rx_char <= c;
        @(posedge core_clk) rx_char_valid <= 1'b0;
        rx_char <= ~c;
    endtask
    task automatic drive_line(input logic v);
        @(posedge core_clk) rx_pin <= v;
    endtask
    task automatic send_break;
        @(posedge core_clk) break_seen <= 1'b1;
        @(posedge core_clk) break_seen <= 1'b0;
    endtask
endmodule

// ===== verification/tb.sv
// Purpose: self-checking bench for the serial data registers and flags
// Assumes: clk_en high except in the freeze test; data_high writes carry test bits both outside and in special mode
// Notes: flag waits are bounded; a lapsed wait ends the run
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0, rd_stb = 1'b0, single_wire = 1'b0, special_mode = 1'b0, stop_mode = 1'b0;
    logic tx_bit_sample = 1'b0, tx_bit_value = 1'b0;
    logic clk_en = 1'b1;
    logic rx_pin, rx_char_valid, break_seen, tx_ninth_bit, tx_nine_bit_fmt, tx_load, irq, stop_wakeup;
    logic [7:0] rdata, tx_data, d;
    logic [8:0] rx_char;
    logic [2:0] test_bits;
    int n_fail = 0, total_checks = 0, wakes = 0;
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (stop_wakeup === 1'b1) wakes <= wakes + 1;
    serial_peer i_peer (.core_clk(core_clk), .rx_pin(rx_pin), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .break_seen(break_seen));
    serial_data_regs i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_pin(rx_pin),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .break_seen(break_seen),
        .single_wire(single_wire), .tx_bit_sample(tx_bit_sample), .tx_bit_value(tx_bit_value),
        .special_mode(special_mode), .stop_mode(stop_mode), .tx_data(tx_data),
        .tx_ninth_bit(tx_ninth_bit), .tx_nine_bit_fmt(tx_nine_bit_fmt), .tx_load(tx_load),
        .test_bits(test_bits), .irq(irq), .stop_wakeup(stop_wakeup));
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk) wr_stb <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk) wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk) rd_stb <= 1'b1;
        addr <= a;
        @(posedge core_clk) rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge core_clk);
        #1;
        if (irq !== 1'b1) begin
            n_fail++;
            $display("MISMATCH at %0t: interrupt wait lapsed", $time);
            final_report();
        end
    endtask
    task automatic t_tx;
        wr(serial_port_pkg::OFF_CTRL, 8'h01);
        wr(serial_port_pkg::OFF_DATA_HIGH, 8'hc7);
        wr(serial_port_pkg::OFF_DATA_LOW, 8'h55);
        check(tx_load, 1'b1);
        check(tx_data, 8'h55);
        check(tx_ninth_bit, 1'b1);
        check(tx_nine_bit_fmt, 1'b1);
        check(test_bits, 3'h0);
        rd(serial_port_pkg::OFF_DATA_HIGH);
        check(d[7], 1'b0);
        wr(serial_port_pkg::OFF_DATA_LOW, 8'haa);
        check(tx_ninth_bit, 1'b1);
        @(posedge core_clk) special_mode <= 1'b1;
        wr(serial_port_pkg::OFF_DATA_HIGH, 8'h05);
        check(test_bits, 3'h5);
        @(posedge core_clk) special_mode <= 1'b0;
        $display("transmit test done");
    endtask
    task automatic t_freeze;
        @(posedge core_clk) clk_en <= 1'b0;
        wr(serial_port_pkg::OFF_DATA_LOW, 8'h3c);
        check(tx_data, 8'haa);
        check(tx_load, 1'b0);
        @(posedge core_clk) clk_en <= 1'b1;
        $display("freeze test done");
    endtask
    task automatic t_rx;
        rd(4'h5);
        check(d, 8'h00);
        i_peer.send_char(9'h1a5);
        rd(serial_port_pkg::OFF_DATA_LOW);
        check(d, 8'ha5);
        rd(serial_port_pkg::OFF_DATA_HIGH);
        check(d[7], 1'b1);
        wr(serial_port_pkg::OFF_CTRL, 8'h00);
        i_peer.send_char(9'h13c);
        rd(serial_port_pkg::OFF_DATA_LOW);
        check(d, 8'h3c);
        rd(serial_port_pkg::OFF_DATA_HIGH);
        check(d[7], 1'b0);
        $display("receive test done");
    endtask
    task automatic t_edge;
        wr(serial_port_pkg::OFF_IRQ_MASK, 8'h07);
        @(posedge core_clk) stop_mode <= 1'b1;
        i_peer.drive_line(1'b0);
        wait_irq();
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h01);
        check(wakes != 0, 1'b1);
        wr(serial_port_pkg::OFF_ALT_STATUS_ONE, 8'h01);
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h00);
        check(irq, 1'b0);
        wr(serial_port_pkg::OFF_CTRL, 8'h02);
        i_peer.drive_line(1'b1);
        wait_irq();
        wr(serial_port_pkg::OFF_ALT_STATUS_ONE, 8'h01);
        i_peer.drive_line(1'b0);
        repeat (10) @(posedge core_clk);
        check(irq, 1'b0);
        $display("edge test done");
    endtask
    task automatic t_flags;
        wr(serial_port_pkg::OFF_CTRL, 8'h0c);
        @(posedge core_clk) single_wire <= 1'b1;
        tx_bit_sample <= 1'b1;
        tx_bit_value <= 1'b1;
        @(posedge core_clk) tx_bit_sample <= 1'b0;
        wait_irq();
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h02);
        wr(serial_port_pkg::OFF_ALT_STATUS_ONE, 8'h02);
        check(irq, 1'b0);
        @(posedge core_clk) tx_bit_sample <= 1'b1;
        @(posedge core_clk) tx_bit_sample <= 1'b0;
        wait_irq();
        wr(serial_port_pkg::OFF_CTRL, 8'h08);
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h00);
        i_peer.send_break();
        wait_irq();
        wr(serial_port_pkg::OFF_ALT_STATUS_ONE, 8'h04);
        check(irq, 1'b0);
        wr(serial_port_pkg::OFF_IRQ_MASK, 8'h00);
        i_peer.send_break();
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h04);
        check(irq, 1'b0);
        wr(serial_port_pkg::OFF_CTRL, 8'h00);
        rd(serial_port_pkg::OFF_ALT_STATUS_ONE);
        check(d, 8'h00);
        $display("flag test done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_tx();
        t_freeze();
        t_rx();
        t_edge();
        t_flags();
        final_report();
    end
endmodule
